// ---- core/irp_pkg.sv ----
package irp_pkg;

  // register byte addresses
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_MATCH  = 8'h04;
  localparam logic [7:0] OFS_POLTHR = 8'h08;
  localparam logic [7:0] OFS_DATA   = 8'h0c;
  localparam logic [7:0] OFS_ST1    = 8'h14;
  localparam logic [7:0] OFS_ST2    = 8'h18;

  // fifo geometry
  localparam int FIFO_DEPTH = 128;
  localparam int PTR_W      = 7;
  localparam int CNT_W      = 8;
  localparam int ENTRY_W    = 11;
  localparam int WIN_MAX    = 32;

  // enable register fields
  localparam int CTL_AME  = 7;
  localparam int CTL_RIE  = 5;
  localparam int CTL_RXON = 4;
  localparam int CTL_TXON = 3;
  localparam logic [7:0] CTL_RESET = 8'h00;

  // match register
  localparam logic [7:0] MATCH_RESET = 8'h00;
  localparam logic [7:0] BROADCAST   = 8'hff;

  // polarity / threshold fields
  localparam int PT_BUS      = 5;
  localparam int PT_TRAIL    = 4;
  localparam int PT_RXPOL    = 3;
  localparam int PT_TXPOL    = 2;
  localparam int PT_TRIG_LSB = 0;
  localparam logic [5:0] PT_RESET = 6'h0c;

  // first status register
  localparam int S1_EOC = 6;
  localparam int S1_FRM = 5;
  localparam int S1_RFS = 4;
  localparam int S1_TAG = 0;

  // second status register
  localparam int S2_OVF = 6;
  localparam int S2_CRC = 5;
  localparam int S2_EOF = 4;
  localparam int S2_TNF = 3;
  localparam int S2_RNE = 2;

  // tag positions in a receive entry
  localparam int TAG_EOF = 8;
  localparam int TAG_CRC = 9;
  localparam int TAG_OVF = 10;

  // threshold levels in bytes
  localparam logic [CNT_W-1:0] THR_8  = 8'h08;
  localparam logic [CNT_W-1:0] THR_16 = 8'h10;
  localparam logic [CNT_W-1:0] THR_32 = 8'h20;

  typedef enum logic [1:0] {RX_HUNT, RX_ADDR, RX_STORE} irp_rx_state_type;

  // trigger code to byte level, also the tag search window
  function automatic logic [CNT_W-1:0] trig_level(input logic [1:0] code);
    logic [CNT_W-1:0] lvl;
    unique case (code)
      2'h0: lvl = THR_8;
      2'h1: lvl = THR_16;
      default: lvl = THR_32;
    endcase
    return lvl;
  endfunction : trig_level

endpackage : irp_pkg

// ---- core/irp_port.sv ----
// Summary of operation
// - an eight-bit match value selects which received frames are kept
// - the match value may be rewritten at any time, even while receiving
// - polarity bits pass data straight when set, invert when clear; reset set
// - data writes push the low byte, or each enabled byte on the 32-bit path, to transmit; reads pop receive bottom
// - each receive entry carries three tags stored with its byte
// - bottom entry tags drive end-of-frame, checksum and overflow flags
// - reading a receive byte advances the fifo and refreshes the flags
// - end/error flag is set while any tag lies in the bottom window
// - end/error flag raises interrupt and holds off receive dma request
// - reset empties both fifos; disabled direction holds its fifo empty
// - an interrupting status bit requests for as long as it stays set
// - sticky bits set by hardware, cleared by writing one only
// - read-only flags follow hardware and ignore writes
// - bus width bit picks 8-bit path or 32-bit little-endian path
// - trailing bit enables the end-of-chain sticky flag and its irq
`timescale 1ns/1ps
`default_nettype none
module irp_port
(
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        ir_rx_pin,
  output logic             rx_serial_data,
  input  wire logic        tx_serial_data,
  output logic             ir_tx_pin,
  input  wire logic        rx_frame_start,
  input  wire logic        rx_byte_valid,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        rx_byte_last,
  input  wire logic        rx_byte_crc_err,
  input  wire logic        rx_framing_err,
  output logic [7:0]       tx_byte,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  input  wire logic        dma_end_of_chain,
  output logic             rx_dma_req,
  output logic             irq
);

  logic [7:0]                 ctrl_q;
  logic [7:0]                 ctrl_d;
  logic [7:0]                 match_value_q;
  logic [7:0]                 match_value_d;
  logic [5:0]                 polthr_q;
  logic [5:0]                 polthr_d;
  logic                       eoc_q;
  logic                       eoc_d;
  logic                       frm_q;
  logic                       frm_d;
  logic [31:0]                rdata_q;
  logic [31:0]                rdata_d;
  logic                       ack_q;
  logic                       ack_d;
  logic [1:0]                 lane_q;
  logic [1:0]                 lane_d;
  irp_pkg::irp_rx_state_type  state_q;
  irp_pkg::irp_rx_state_type  state_d;
  logic                       ovr_pend_q;
  logic                       ovr_pend_d;
  logic                       rxd_q;
  logic                       rxd_d;
  logic                       txd_q;
  logic                       txd_d;
  logic [7:0]                 tx_mem [irp_pkg::FIFO_DEPTH];
  logic [irp_pkg::PTR_W-1:0]  tx_wr_q;
  logic [irp_pkg::PTR_W-1:0]  tx_wr_d;
  logic [irp_pkg::PTR_W-1:0]  tx_rd_q;
  logic [irp_pkg::PTR_W-1:0]  tx_rd_d;
  logic [irp_pkg::CNT_W-1:0]  tx_cnt_q;
  logic [irp_pkg::CNT_W-1:0]  tx_cnt_d;

  logic                       rx_on;
  logic                       tx_on;
  logic                       req;
  logic                       working;
  logic                       is_data;
  logic [1:0]                 last_lane;
  logic                       lane_on;
  logic                       wr_fin;
  logic                       data_rd_step;
  logic                       data_wr_step;
  logic [31:0]                reg_mux;
  logic [7:0]                 st1;
  logic [7:0]                 st2;
  logic                       tx_full;
  logic                       tx_empty;
  logic                       tx_push;
  logic                       tx_pop;
  logic [7:0]                 tx_push_byte;
  logic                       accept_now;
  logic                       rx_want;
  logic                       rx_push;
  logic [irp_pkg::ENTRY_W-1:0] rx_entry;
  logic [irp_pkg::ENTRY_W-1:0] rx_bottom;
  logic [irp_pkg::CNT_W-1:0]  rx_count;
  logic                       rx_full;
  logic                       rx_empty;
  logic                       tagw;
  logic                       rfs;

  assign rx_on = ctrl_q[irp_pkg::CTL_RXON];
  assign tx_on = ctrl_q[irp_pkg::CTL_TXON];

  // bus handshake: one wait per byte lane on the data port
  assign req       = avs_read | avs_write;
  assign working   = req & ~ack_q;
  assign is_data   = avs_address == irp_pkg::OFS_DATA;
  assign last_lane = (is_data & polthr_q[irp_pkg::PT_BUS]) ? 2'h3 : 2'h0;
  assign lane_on   = polthr_q[irp_pkg::PT_BUS] ? avs_byteenable[lane_q]
                                               : 1'b1;
  assign wr_fin       = avs_write & ack_q;
  assign data_rd_step = working & is_data & avs_read & lane_on;
  assign data_wr_step = working & is_data & avs_write & lane_on;
  assign avs_waitrequest = working;
  assign avs_readdata    = rdata_q;

  // status words
  always_comb
  begin
    st1 = 8'h00;
    st1[irp_pkg::S1_EOC] = eoc_q;
    st1[irp_pkg::S1_FRM] = frm_q;
    st1[irp_pkg::S1_RFS] = rfs;
    st1[irp_pkg::S1_TAG] = tagw;
    st2 = 8'h00;
    st2[irp_pkg::S2_OVF] = rx_bottom[irp_pkg::TAG_OVF];
    st2[irp_pkg::S2_CRC] = rx_bottom[irp_pkg::TAG_CRC];
    st2[irp_pkg::S2_EOF] = rx_bottom[irp_pkg::TAG_EOF];
    st2[irp_pkg::S2_TNF] = ~tx_full;
    st2[irp_pkg::S2_RNE] = ~rx_empty;
  end

  always_comb
  begin
    unique case (avs_address)
      irp_pkg::OFS_CTRL:   reg_mux = {24'h0, ctrl_q};
      irp_pkg::OFS_MATCH:  reg_mux = {24'h0, match_value_q};
      irp_pkg::OFS_POLTHR: reg_mux = {26'h0, polthr_q};
      irp_pkg::OFS_ST1:    reg_mux = {24'h0, st1};
      irp_pkg::OFS_ST2:    reg_mux = {24'h0, st2};
      default:             reg_mux = 32'h0;
    endcase
  end

  // bus and register next state
  always_comb
  begin
    ack_d         = working & (lane_q == last_lane);
    lane_d        = (working & (lane_q != last_lane)) ? lane_q + 2'h1 : 2'h0;
    rdata_d       = rdata_q;
    ctrl_d        = ctrl_q;
    match_value_d = match_value_q;
    polthr_d      = polthr_q;
    if (working)
    begin
      if (lane_q == 2'h0)
        rdata_d = is_data ? 32'h0 : reg_mux;
      if (data_rd_step & ~rx_empty)
        rdata_d[{lane_q, 3'h0} +: 8] = rx_bottom[7:0];
    end
    if (wr_fin & avs_byteenable[0])
    begin
      unique case (avs_address)
        irp_pkg::OFS_CTRL:   ctrl_d = avs_writedata[7:0];
        irp_pkg::OFS_MATCH:  match_value_d = avs_writedata[7:0];
        irp_pkg::OFS_POLTHR: polthr_d = avs_writedata[5:0];
        default:             ctrl_d = ctrl_q;
      endcase
    end
    eoc_d = eoc_q;
    if (wr_fin & (avs_address == irp_pkg::OFS_ST1)
        & avs_writedata[irp_pkg::S1_EOC])
      eoc_d = 1'b0;
    if (dma_end_of_chain & polthr_q[irp_pkg::PT_TRAIL])
      eoc_d = 1'b1;
    frm_d = frm_q;
    if (wr_fin & (avs_address == irp_pkg::OFS_ST1)
        & avs_writedata[irp_pkg::S1_FRM])
      frm_d = 1'b0;
    if (rx_framing_err & rx_on)
      frm_d = 1'b1;
  end

  // polarity on the serial pins
  always_comb
  begin
    rxd_d = ir_rx_pin ^ ~polthr_q[irp_pkg::PT_RXPOL];
    txd_d = tx_serial_data ^ ~polthr_q[irp_pkg::PT_TXPOL];
  end
  assign rx_serial_data = rxd_q;
  assign ir_tx_pin      = txd_q;

  // receive frame acceptance
  assign accept_now = ~ctrl_q[irp_pkg::CTL_AME]
                      | (rx_byte == match_value_q)
                      | (rx_byte == irp_pkg::BROADCAST);
  assign rx_want = rx_on & rx_byte_valid
                   & ((state_q == irp_pkg::RX_STORE)
                      | ((state_q == irp_pkg::RX_ADDR) & accept_now));
  assign rx_push  = rx_want & ~rx_full;
  assign rx_entry = {ovr_pend_q, rx_byte_crc_err, rx_byte_last, rx_byte};

  always_comb
  begin
    state_d    = state_q;
    ovr_pend_d = ovr_pend_q;
    if (!rx_on)
    begin
      state_d    = irp_pkg::RX_HUNT;
      ovr_pend_d = 1'b0;
    end
    else if (rx_frame_start)
      state_d = irp_pkg::RX_ADDR;
    else if (rx_byte_valid)
    begin
      unique case (state_q)
        irp_pkg::RX_ADDR:
          state_d = accept_now ? irp_pkg::RX_STORE : irp_pkg::RX_HUNT;
        irp_pkg::RX_STORE:
          state_d = rx_byte_last ? irp_pkg::RX_HUNT : irp_pkg::RX_STORE;
        irp_pkg::RX_HUNT:
          state_d = irp_pkg::RX_HUNT;
      endcase
    end
    if (rx_on & rx_want & rx_full)
      ovr_pend_d = 1'b1;
    else if (rx_push)
      ovr_pend_d = 1'b0;
  end

  irp_rx_fifo u_rx_fifo
  (
    .core_clk   (core_clk),
    .nrst       (nrst),
    .flush      (~rx_on),
    .push       (rx_push),
    .push_entry (rx_entry),
    .pop        (data_rd_step),
    .trig       (polthr_q[irp_pkg::PT_TRIG_LSB +: 2]),
    .bottom     (rx_bottom),
    .count      (rx_count),
    .full       (rx_full),
    .empty      (rx_empty),
    .tagw       (tagw)
  );

  // service request, dma gating and interrupt
  assign rfs = rx_on & (rx_count >= irp_pkg::trig_level(
                 polthr_q[irp_pkg::PT_TRIG_LSB +: 2]));
  assign rx_dma_req = rfs & ~tagw;
  assign irq = tagw | frm_q | eoc_q
               | (rfs & ctrl_q[irp_pkg::CTL_RIE]);

  // transmit fifo
  assign tx_full      = tx_cnt_q == irp_pkg::CNT_W'(irp_pkg::FIFO_DEPTH);
  assign tx_empty     = tx_cnt_q == '0;
  assign tx_push      = data_wr_step & tx_on & ~tx_full;
  assign tx_pop       = tx_ready & ~tx_empty & tx_on;
  assign tx_push_byte = avs_writedata[{lane_q, 3'h0} +: 8];
  assign tx_valid     = ~tx_empty;
  assign tx_byte      = tx_empty ? 8'h00 : tx_mem[tx_rd_q];

  always_comb
  begin
    tx_wr_d  = tx_wr_q;
    tx_rd_d  = tx_rd_q;
    tx_cnt_d = tx_cnt_q;
    if (!tx_on)
    begin
      tx_wr_d  = '0;
      tx_rd_d  = '0;
      tx_cnt_d = '0;
    end
    else
    begin
      if (tx_push)
        tx_wr_d = tx_wr_q + 7'h01;
      if (tx_pop)
        tx_rd_d = tx_rd_q + 7'h01;
      if (tx_push & ~tx_pop)
        tx_cnt_d = tx_cnt_q + 8'h01;
      else if (tx_pop & ~tx_push)
        tx_cnt_d = tx_cnt_q - 8'h01;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (tx_push)
      tx_mem[tx_wr_q] <= tx_push_byte;
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_q        <= irp_pkg::CTL_RESET;
      match_value_q <= irp_pkg::MATCH_RESET;
      polthr_q      <= irp_pkg::PT_RESET;
      eoc_q         <= 1'b0;
      frm_q         <= 1'b0;
      rdata_q       <= 32'h0;
      ack_q         <= 1'b0;
      lane_q        <= 2'h0;
      state_q       <= irp_pkg::RX_HUNT;
      ovr_pend_q    <= 1'b0;
      rxd_q         <= 1'b0;
      txd_q         <= 1'b0;
      tx_wr_q       <= '0;
      tx_rd_q       <= '0;
      tx_cnt_q      <= '0;
    end
    else
    begin
      ctrl_q        <= ctrl_d;
      match_value_q <= match_value_d;
      polthr_q      <= polthr_d;
      eoc_q         <= eoc_d;
      frm_q         <= frm_d;
      rdata_q       <= rdata_d;
      ack_q         <= ack_d;
      lane_q        <= lane_d;
      state_q       <= state_d;
      ovr_pend_q    <= ovr_pend_d;
      rxd_q         <= rxd_d;
      txd_q         <= txd_d;
      tx_wr_q       <= tx_wr_d;
      tx_rd_q       <= tx_rd_d;
      tx_cnt_q      <= tx_cnt_d;
    end
  end

endmodule : irp_port
`default_nettype wire

// ---- core/irp_rx_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module irp_rx_fifo
(
  input  wire logic                            core_clk,
  input  wire logic                            nrst,
  input  wire logic                            flush,
  input  wire logic                            push,
  input  wire logic [irp_pkg::ENTRY_W-1:0]     push_entry,
  input  wire logic                            pop,
  input  wire logic [1:0]                      trig,
  output logic      [irp_pkg::ENTRY_W-1:0]     bottom,
  output logic      [irp_pkg::CNT_W-1:0]       count,
  output logic                                 full,
  output logic                                 empty,
  output logic                                 tagw
);

  logic [irp_pkg::ENTRY_W-1:0] mem [irp_pkg::FIFO_DEPTH];
  logic [irp_pkg::PTR_W-1:0]   wr_q;
  logic [irp_pkg::PTR_W-1:0]   wr_d;
  logic [irp_pkg::PTR_W-1:0]   rd_q;
  logic [irp_pkg::PTR_W-1:0]   rd_d;
  logic [irp_pkg::CNT_W-1:0]   cnt_q;
  logic [irp_pkg::CNT_W-1:0]   cnt_d;
  logic                        do_push;
  logic                        do_pop;
  logic [irp_pkg::CNT_W-1:0]   win;
  logic [irp_pkg::PTR_W-1:0]   idx;

  assign count  = cnt_q;
  assign full   = cnt_q == irp_pkg::CNT_W'(irp_pkg::FIFO_DEPTH);
  assign empty  = cnt_q == '0;
  assign bottom = empty ? '0 : mem[rd_q];
  assign do_push = push & ~full & ~flush;
  assign do_pop  = pop & ~empty & ~flush;
  assign win     = irp_pkg::trig_level(trig);

  always_comb
  begin
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    if (flush)
    begin
      wr_d  = '0;
      rd_d  = '0;
      cnt_d = '0;
    end
    else
    begin
      if (do_push)
        wr_d = wr_q + 7'h01;
      if (do_pop)
        rd_d = rd_q + 7'h01;
      if (do_push & ~do_pop)
        cnt_d = cnt_q + 8'h01;
      else if (do_pop & ~do_push)
        cnt_d = cnt_q - 8'h01;
    end
  end

  // any tag inside the bottom window of valid entries
  always_comb
  begin
    tagw = 1'b0;
    idx = rd_q;
    for (int i = 0; i < irp_pkg::WIN_MAX; i++)
    begin
      idx = rd_q + irp_pkg::PTR_W'(i);
      if ((irp_pkg::CNT_W'(i) < win) && (irp_pkg::CNT_W'(i) < cnt_q)
          && (mem[idx][irp_pkg::TAG_OVF:irp_pkg::TAG_EOF] != 3'h0))
        tagw = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // tags travel with their byte in the same word
  always_ff @(posedge core_clk)
  begin
    if (do_push)
      mem[wr_q] <= push_entry;
  end

endmodule : irp_rx_fifo
`default_nettype wire

// ---- dv/irp_link_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module irp_link_model
(
  input wire logic       core_clk,
  output logic           rx_frame_start,
  output logic           rx_framing_err,
  output logic           rx_byte_valid,
  output logic [7:0]     rx_byte,
  output logic           rx_byte_last,
  output logic           rx_byte_crc_err,
  input wire logic [7:0] tx_byte,
  input wire logic       tx_valid,
  output logic           tx_ready
);
  logic [7:0] txq[$];
  int         stall = 0;
  initial {rx_frame_start, rx_framing_err, rx_byte_valid} = 3'h0;
  initial {rx_byte, rx_byte_last, rx_byte_crc_err, tx_ready} = 11'h0;
  // start flag or framing error pulse
  task automatic pulse(input logic f);
    @(posedge core_clk);
    if (f)
      rx_framing_err <= 1'b1;
    else
      rx_frame_start <= 1'b1;
    @(posedge core_clk);
    rx_framing_err <= 1'b0;
    rx_frame_start <= 1'b0;
  endtask : pulse
  // one received byte, data line scrambled once released
  task automatic put(input logic [7:0] b, input logic l, input logic c);
    @(posedge core_clk);
    {rx_byte_valid, rx_byte, rx_byte_last, rx_byte_crc_err} <= {1'b1, b, l, c};
    @(posedge core_clk);
    {rx_byte_valid, rx_byte, rx_byte_last, rx_byte_crc_err} <= {1'b0, ~b, 2'h0};
  endtask : put
  // transmit sink with random stalls
  always @(posedge core_clk)
  begin
    if (tx_valid && tx_ready)
      txq.push_back(tx_byte);
    tx_ready <= ($urandom % 100) >= stall;
  end
endmodule : irp_link_model
`default_nettype wire

// ---- dv/irp_port_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module irp_port_chk
(
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        ir_rx_pin,
  input wire logic        rx_serial_data,
  input wire logic        tx_serial_data,
  input wire logic        ir_tx_pin,
  input wire logic        rx_framing_err,
  input wire logic [7:0]  tx_byte,
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire logic        rx_dma_req,
  input wire logic        irq
);
  logic       up_q, wq_q, bus_q, rxpol_q, txpol_q, txon_q, rxon_q;
  logic [7:0] mt_q;
  logic       wr_ok, dat;
  assign wr_ok = avs_write & ~avs_waitrequest & avs_byteenable[0];
  assign dat   = avs_address == irp_pkg::OFS_DATA;
  // mirrors of the settings the assertions depend on
  always_ff @(posedge core_clk or negedge nrst)
    if (!nrst)
    begin
      {up_q, wq_q, bus_q, rxpol_q, txpol_q, txon_q, rxon_q} <= 7'h0c;
      mt_q <= 8'h00;
    end
    else
    begin
      up_q <= 1'b1;
      wq_q <= (avs_read | avs_write) & avs_waitrequest;
      if (wr_ok && avs_address == irp_pkg::OFS_POLTHR)
        {bus_q, rxpol_q, txpol_q} <= {avs_writedata[5], avs_writedata[3:2]};
      if (wr_ok && avs_address == irp_pkg::OFS_CTRL)
        {rxon_q, txon_q} <= avs_writedata[4:3];
      if (wr_ok && avs_address == irp_pkg::OFS_MATCH)
        mt_q <= avs_writedata[7:0];
    end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  a_rx_polarity: assert property (up_q |-> rx_serial_data ==
    ($past(ir_rx_pin) ^ ~$past(rxpol_q))) else $error("rx pin polarity");
  a_tx_polarity: assert property (up_q |-> ir_tx_pin ==
    ($past(tx_serial_data) ^ ~$past(txpol_q))) else $error("tx pin polarity");
  a_wait_short: assert property ((avs_read | avs_write) && !wq_q &&
    !(dat && bus_q) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("short access wait");
  a_wait_wide: assert property ((avs_read | avs_write) && !wq_q &&
    dat && bus_q |-> avs_waitrequest [*4] ##1 !avs_waitrequest)
    else $error("wide access wait");
  a_match_read: assert property (avs_read && !avs_waitrequest &&
    avs_address == irp_pkg::OFS_MATCH |-> avs_readdata[7:0] == mt_q)
    else $error("match value read");
  a_tx_off: assert property (!txon_q && !$past(txon_q)
    |-> !tx_valid) else $error("tx fifo not empty while off");
  a_rx_off: assert property (!rxon_q && !$past(rxon_q)
    |-> !rx_dma_req) else $error("rx request while off");
  a_frame_irq: assert property (rx_framing_err && rxon_q |=> irq)
    else $error("framing error without irq");
  a_tx_hold: assert property (tx_valid && !tx_ready && txon_q |=>
    !txon_q || (tx_valid && $stable(tx_byte))) else $error("tx byte not held");
endmodule : irp_port_chk
bind irp_port irp_port_chk chk_u (.core_clk, .nrst, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
  .avs_waitrequest, .ir_rx_pin, .rx_serial_data, .tx_serial_data, .ir_tx_pin,
  .rx_framing_err, .tx_byte, .tx_valid, .tx_ready, .rx_dma_req, .irq);
`default_nettype wire

// ---- dv/irp_port_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module irp_port_tb;
  logic        core_clk, nrst, avs_read, avs_write, avs_waitrequest;
  logic [7:0]  avs_address, rx_byte, tx_byte, ctl, mtc, pt, b;
  logic [31:0] avs_writedata, avs_readdata, r, rn;
  logic [3:0]  avs_byteenable;
  logic        ir_rx_pin, rx_serial_data, tx_serial_data, ir_tx_pin, lost;
  logic        rx_frame_start, rx_byte_valid, rx_byte_last, rx_byte_crc_err;
  logic        rx_framing_err, tx_valid, tx_ready, dma_end_of_chain;
  logic        rx_dma_req, irq, frm_m, eoc_m;
  logic [10:0] rxq[$];
  logic [7:0]  txq[$];
  int          num_errors = 0, n_compared = 0, cyc = 0, i, k;
  irp_port dut_u (.core_clk, .nrst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .ir_rx_pin, .rx_serial_data, .tx_serial_data, .ir_tx_pin, .rx_frame_start,
    .rx_byte_valid, .rx_byte, .rx_byte_last, .rx_byte_crc_err, .rx_framing_err,
    .tx_byte, .tx_valid, .tx_ready, .dma_end_of_chain, .rx_dma_req, .irq);
  irp_link_model link_u (.core_clk, .rx_frame_start, .rx_framing_err,
    .rx_byte_valid, .rx_byte, .rx_byte_last, .rx_byte_crc_err, .tx_byte,
    .tx_valid, .tx_ready);
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : cmp
  task automatic cmp_bit(input string n, input logic e, input logic s);
    cmp(n, {31'h0, e}, {31'h0, s});
  endtask : cmp_bit
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    @(posedge core_clk);
    avs_address <= a;
    {avs_write, avs_read, avs_writedata, avs_byteenable} <= {w, !w, d, be};
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    {avs_write, avs_read} <= 2'h0;
  endtask : bus
  task automatic setc(input logic [7:0] c);
    ctl = c;
    bus(1, irp_pkg::OFS_CTRL, {24'h0, c}, 4'h1);
    if (!c[4])
    begin
      rxq.delete();
      lost = 0;
    end
  endtask : setc
  task automatic setp(input logic [7:0] p);
    setc(8'h00);
    pt = p;
    bus(1, irp_pkg::OFS_POLTHR, {24'h0, p}, 4'h1); // enables clear
  endtask : setp
  task automatic chk_st();
    logic e, rfs;
    int   lv;
    lv = pt[1:0] == 2'h0 ? 8 : pt[1:0] == 2'h1 ? 16 : 32;
    e = 0;
    for (k = 0; k < rxq.size() && k < lv; k++) e |= |rxq[k][10:8];
    rfs = ctl[4] && rxq.size() >= lv;
    bus(0, irp_pkg::OFS_ST1, 0, 4'hf);
    cmp("st1", {25'h0, eoc_m, frm_m, rfs, 3'h0, e}, r & 32'h71);
    bus(0, irp_pkg::OFS_ST2, 0, 4'hf);
    cmp("st2", {25'h0, rxq.size() ? rxq[0][10:8] : 3'h0, 1'b1, rxq.size() != 0,
      2'h0}, r & 32'h7c);
    @(negedge core_clk);
    cmp_bit("dma", rfs & !e, rx_dma_req);
    cmp_bit("irq", e | frm_m | eoc_m | (rfs & ctl[5]), irq);
  endtask : chk_st
  task automatic pop();
    chk_st(); // flags before removal
    b = rxq.size() ? rxq[0][7:0] : 8'h00;
    if (rxq.size()) void'(rxq.pop_front());
    bus(0, irp_pkg::OFS_DATA, 0, 4'h1);
    cmp("rx byte", {24'h0, b}, {24'h0, r[7:0]});
  endtask : pop
  task automatic frame(input logic [7:0] a, input int n, input logic crc);
    logic keep, l;
    link_u.pulse(0);
    keep = ctl[4] && (!ctl[7] || a == mtc || a == 8'hff);
    for (int j = 0; j < n; j++)
    begin
      rn = $urandom;
      b = j ? rn[7:0] : a;
      l = j == n - 1;
      link_u.put(b, l, crc & l);
      if (keep && rxq.size() == 128)
        lost = 1;
      else if (keep)
      begin
        rxq.push_back({lost, crc & l, l, b});
        lost = 0;
      end
    end
  endtask : frame
  initial
  begin
    core_clk = 0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      num_errors++;
      end_of_test();
    end
  end
  initial
  begin
    {nrst, avs_read, avs_write, avs_address, avs_writedata} = 0;
    {avs_byteenable, ir_rx_pin, tx_serial_data, dma_end_of_chain} = 0;
    {ctl, mtc, pt, lost, frm_m, eoc_m} = 8'h0c << 3;
    rn = $urandom(27708);
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    for (i = 0; i < 4; i++)
    begin
      bus(0, 8'(4 * i), 0, 4'hf);
      cmp("reset reg", i == 2 ? 32'h0c : 32'h0, r & 32'hff);
    end
    chk_st();
    $display("test reset done");
    for (i = 0; i < 2; i++)
    begin
      if (i) setp(8'h00);
      @(posedge core_clk);
      rn = $urandom;
      {ir_rx_pin, tx_serial_data} <= rn[1:0];
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      cmp_bit("rx pin", ir_rx_pin ^ ~pt[3], rx_serial_data);
      cmp_bit("tx pin", tx_serial_data ^ ~pt[2], ir_tx_pin);
    end
    setp(8'h0c);
    $display("test polarity done");
    setc(8'h90);
    rn = $urandom;
    mtc = rn[7:0] & 8'hfd;
    bus(1, irp_pkg::OFS_MATCH, {24'h0, mtc}, 4'h1); // while receiving
    bus(0, irp_pkg::OFS_MATCH, 0, 4'hf);
    cmp("match", {24'h0, mtc}, r & 32'hff);
    frame(mtc, 3, 0);
    frame(mtc ^ 8'h01, 4, 0);
    frame(8'hff, 2, 1);
    frame(mtc, 10, 0);
    while (rxq.size()) pop();
    pop();
    $display("test match done");
    setc(8'h10);
    frame(8'h00, 129, 0);
    pop();
    frame(8'h01, 1, 0);
    bus(1, irp_pkg::OFS_ST2, 32'hff, 4'h1);
    while (rxq.size()) pop();
    $display("test overrun done");
    for (i = 0; i < 4; i++)
    begin
      setp(8'h0c | 8'(i));
      setc(8'h30);
      frame(8'h00, (i == 0 ? 8 : i == 1 ? 16 : 32) + 1, 0);
      while (rxq.size()) pop();
    end
    $display("test threshold done");
    link_u.pulse(1);
    frm_m = 1;
    chk_st();
    bus(1, irp_pkg::OFS_ST1, 32'h00, 4'h1);
    chk_st();
    bus(1, irp_pkg::OFS_ST1, 32'h20, 4'h1);
    frm_m = 0;
    chk_st();
    for (i = 0; i < 2; i++)
    begin
      if (i) setp(8'h1c);
      setc(8'h10);
      @(posedge core_clk) dma_end_of_chain <= 1'b1;
      @(posedge core_clk) dma_end_of_chain <= 1'b0;
      eoc_m = i[0];
      chk_st();
    end
    bus(1, irp_pkg::OFS_ST1, 32'h40, 4'h1);
    eoc_m = 0;
    chk_st();
    $display("test sticky done");
    link_u.stall = 50;
    setc(8'h00);
    bus(1, irp_pkg::OFS_DATA, 32'h5a, 4'h1);
    setc(8'h08);
    for (i = 0; i < 5; i++)
    begin
      if (i == 4)
        while (link_u.txq.size() < txq.size()) @(posedge core_clk);
      if (i == 4) setp(8'h2c);
      if (i == 4) setc(8'h18);
      rn = $urandom;
      bus(1, irp_pkg::OFS_DATA, rn, 4'hf);
      for (k = 0; k < (i == 4 ? 4 : 1); k++) txq.push_back(rn[8*k+:8]);
    end
    frame(8'h00, 4, 0);
    rn = {rxq[3][7:0], rxq[2][7:0], rxq[1][7:0], rxq[0][7:0]};
    bus(0, irp_pkg::OFS_DATA, 0, 4'hf);
    cmp("rx word", rn, r);
    i = 0;
    while (link_u.txq.size() < txq.size() && i < 500)
    begin
      @(posedge core_clk);
      i++;
    end
    cmp("tx count", txq.size(), link_u.txq.size());
    foreach (txq[i]) cmp("tx byte", txq[i], link_u.txq[i]);
    $display("test transmit done");
    end_of_test();
  end
endmodule : irp_port_tb
`default_nettype wire
